// ===== verilog/charger_ctrl_regs.svh
// Offsets, reset values, field positions and masks of the charger configuration bank.
// Included by the register bank module only; holds definitions only.
`ifndef CHARGER_CTRL_REGS_SVH
`define CHARGER_CTRL_REGS_SVH

`define OFS_PRE_TERM      8'h04
`define OFS_CTL1          8'h05
`define OFS_CTL2          8'h06
`define OFS_CTL3          8'h07
`define OFS_DERATE        8'h08
`define OFS_OTG           8'h09
`define OFS_OPT_ILIM      8'h0A

`define RST_PRE_TERM      8'h22
`define RST_CTL1          8'h9D
`define RST_CTL2          8'h7D
`define RST_CTL3          8'h0A
`define RST_DERATE        8'h0D
`define RST_OTG           8'hF6
`define RST_OPT_ILIM      5'h00

// Writable bits of control one (bit 6 reserved, reads zero)
`define CTL1_WMASK        8'hBF
// Bits kept through a watchdog expiry
`define CTL2_WD_KEEP      8'h03
`define CTL3_WD_KEEP      8'h8F
// Stored bits of control three (bit 6 is the self-clearing kick)
`define CTL3_WMASK        8'hBF

`define PRE_HI            7
`define PRE_LO            4
`define END_HI            3
`define END_LO            0
`define C1_TERM           7
`define C1_WD_HI          5
`define C1_WD_LO          4
`define C1_TMR_EN         3
`define C1_DUR_HI         2
`define C1_DUR_LO         1
`define C1_HALF           0
`define C2_OTG            7
`define C2_AUTO           6
`define C2_DIE_TEMP_THRESHOLD_HI        5
`define C2_DIE_TEMP_THRESHOLD_LO        4
`define C2_CHG            3
`define C2_LOWV           2
`define C2_RECH_HI        1
`define C2_RECH_LO        0
`define C3_PFM_OFF        7
`define C3_KICK           6
`define C3_TOP_HI         5
`define C3_TOP_LO         4
`define C3_SYS_HI         3
`define C3_SYS_LO         0
`define D_HOT_HI          7
`define D_HOT_LO          6
`define D_COLD            5
`define D_WV_HI           4
`define D_WV_LO           3
`define D_WI              2
`define D_CI_HI           1
`define D_CI_LO           0
`define OTG_I_HI          7
`define OTG_I_LO          4
`define OTG_V_HI          3
`define OTG_V_LO          0
`define OTG_V_MAX         4'hA
`define OPT_ILIM_W        5

`endif

// ===== verilog/charger_ctrl_pkg.sv
// Types shared by the charger configuration bank and its bench.
// Assumes nothing of its surroundings.
package charger_ctrl_pkg;
   typedef logic [7:0] reg_byte_t;
   typedef logic [7:0] reg_addr_t;
   typedef logic [3:0] nibble_t;
   typedef logic [1:0] code2_t;
endpackage

// ===== verilog/charger_control_registers.sv
// Charger configuration register bank, offsets 0x04 to 0x0A.
// Assumes a serial bus front end that hands over decoded byte reads and writes, and
// charger logic that presents register-reset and watchdog-expiry pulses.
`timescale 1ns/1ns
`include "charger_ctrl_regs.svh"

module charger_control_registers (
   input  wire logic                      I_REF_CLK,
   input  wire logic                      I_SYS_RST,
   input  wire logic                      I_WR_EN,
   input  wire logic                      I_RD_EN,
   input  wire charger_ctrl_pkg::reg_addr_t I_ADDR,
   input  wire charger_ctrl_pkg::reg_byte_t I_WR_DATA,
   input  wire logic                      I_REG_RESET,
   input  wire logic                      I_WATCHDOG_EXPIRED,
   input  wire logic                      I_INPUT_REG_ACTIVE,
   input  wire logic                      I_THERMAL_REG_ACTIVE,
   input  wire logic                      I_SOURCE_PLUG_IN,
   input  wire logic [4:0]                I_OPT_INPUT_CURRENT,
   output charger_ctrl_pkg::reg_byte_t    O_RD_DATA,
   output logic                           O_RD_VALID,
   output charger_ctrl_pkg::nibble_t      O_PRECHARGE_CURRENT_CODE,
   output charger_ctrl_pkg::nibble_t      O_END_CURRENT_CODE,
   output logic                           O_TERMINATION_ENABLE,
   output charger_ctrl_pkg::code2_t       O_HOST_TIMEOUT_PERIOD,
   output logic                           O_SAFETY_TIMER_ENABLE,
   output charger_ctrl_pkg::code2_t       O_FAST_CHARGE_DURATION,
   output logic                           O_HALF_SPEED_TIMER_ENABLE,
   output logic                           O_BUCK_OUTPUT_ENABLE,
   output logic                           O_AUTO_SOURCE_DETECT_ENABLE,
   output charger_ctrl_pkg::code2_t       O_DIE_TEMP_THRESHOLD,
   output logic                           O_CHARGING_ENABLE,
   output logic                           O_PRECHARGE_EXIT_THRESHOLD,
   output charger_ctrl_pkg::code2_t       O_RECHARGE_OFFSET,
   output logic                           O_LIGHT_LOAD_MODE_OFF,
   output charger_ctrl_pkg::code2_t       O_AFTER_CHARGE_DURATION,
   output charger_ctrl_pkg::nibble_t      O_MIN_SYSTEM_VOLTAGE,
   output charger_ctrl_pkg::code2_t       O_BUCK_HOT_THRESHOLD,
   output logic                           O_BUCK_COLD_THRESHOLD,
   output charger_ctrl_pkg::code2_t       O_WARM_VOLTAGE_SETTING,
   output logic                           O_WARM_CURRENT_SETTING,
   output charger_ctrl_pkg::code2_t       O_COOL_CURRENT_SETTING,
   output charger_ctrl_pkg::nibble_t      O_BUCK_CURRENT_LIMIT,
   output charger_ctrl_pkg::nibble_t      O_BUCK_VOLTAGE_SETTING,
   output logic                           O_BUCK_ACTIVE,
   output logic                           O_SAFETY_HALF_RATE,
   output logic                           O_RUN_SOURCE_DETECT,
   output logic                           O_WATCHDOG_RESTART,
   output logic                           O_SAFETY_TIMER_RESTART
);
   import charger_ctrl_pkg::*;

   reg_byte_t        pre_term;
   reg_byte_t        ctl1;
   reg_byte_t        ctl2;
   reg_byte_t        ctl3;
   reg_byte_t        derate;
   reg_byte_t        otg;
   logic [4:0]       opt_ilim;
   logic             kick;
   logic             wr_ctl1;
   logic             wr_ctl3;
   logic             period_change;
   logic             duration_change;
   reg_byte_t        next_rd_data;

   function automatic logic hit(input reg_addr_t addr, input reg_addr_t ofs);
      hit = (addr == ofs);
   endfunction

   function automatic reg_byte_t wd_clear(input reg_byte_t cur, input reg_byte_t rst,
                                          input reg_byte_t keep);
      wd_clear = (cur & keep) | (rst & ~keep);
   endfunction

   assign wr_ctl1         = I_WR_EN && hit(I_ADDR, `OFS_CTL1);
   assign wr_ctl3         = I_WR_EN && hit(I_ADDR, `OFS_CTL3);
   assign period_change   = wr_ctl1 && (I_WR_DATA[`C1_WD_HI:`C1_WD_LO] != ctl1[`C1_WD_HI:`C1_WD_LO]);
   assign duration_change = wr_ctl1 && (I_WR_DATA[`C1_DUR_HI:`C1_DUR_LO] != ctl1[`C1_DUR_HI:`C1_DUR_LO]);

   always_ff @(posedge I_REF_CLK) begin
      if (I_SYS_RST || I_REG_RESET) begin
         pre_term <= `RST_PRE_TERM;
      end else if (I_WR_EN && hit(I_ADDR, `OFS_PRE_TERM)) begin
         pre_term <= I_WR_DATA;
      end else if (I_WATCHDOG_EXPIRED) begin
         pre_term <= `RST_PRE_TERM;
      end
   end

   always_ff @(posedge I_REF_CLK) begin
      if (I_SYS_RST || I_REG_RESET) begin
         ctl1 <= `RST_CTL1;
      end else if (wr_ctl1) begin
         ctl1 <= I_WR_DATA & `CTL1_WMASK;
      end else if (I_WATCHDOG_EXPIRED) begin
         ctl1 <= `RST_CTL1;
      end
   end

   always_ff @(posedge I_REF_CLK) begin
      if (I_SYS_RST || I_REG_RESET) begin
         ctl2 <= `RST_CTL2;
      end else if (I_WR_EN && hit(I_ADDR, `OFS_CTL2)) begin
         ctl2 <= I_WR_DATA;
      end else if (I_WATCHDOG_EXPIRED) begin
         ctl2 <= wd_clear(ctl2, `RST_CTL2, `CTL2_WD_KEEP);
      end
   end

   always_ff @(posedge I_REF_CLK) begin
      if (I_SYS_RST || I_REG_RESET) begin
         ctl3 <= `RST_CTL3;
      end else if (wr_ctl3) begin
         ctl3 <= I_WR_DATA & `CTL3_WMASK;
      end else if (I_WATCHDOG_EXPIRED) begin
         ctl3 <= wd_clear(ctl3, `RST_CTL3, `CTL3_WD_KEEP);
      end
   end

   always_ff @(posedge I_REF_CLK) begin
      if (I_SYS_RST || I_REG_RESET) begin
         kick <= 1'b0;
      end else if (wr_ctl3 && I_WR_DATA[`C3_KICK]) begin
         kick <= 1'b1;
      end else begin
         kick <= 1'b0;
      end
   end

   always_ff @(posedge I_REF_CLK) begin
      if (I_SYS_RST || I_REG_RESET) begin
         derate <= `RST_DERATE;
      end else if (I_WR_EN && hit(I_ADDR, `OFS_DERATE)) begin
         derate <= I_WR_DATA;
      end else if (I_WATCHDOG_EXPIRED) begin
         derate <= `RST_DERATE;
      end
   end

   always_ff @(posedge I_REF_CLK) begin
      if (I_SYS_RST || I_REG_RESET) begin
         otg <= `RST_OTG;
      end else if (I_WR_EN && hit(I_ADDR, `OFS_OTG)) begin
         otg <= I_WR_DATA;
      end else if (I_WATCHDOG_EXPIRED) begin
         otg <= `RST_OTG;
      end
   end

   // read-only sample, writes never reach it
   always_ff @(posedge I_REF_CLK) begin
      if (I_SYS_RST) begin
         opt_ilim <= `RST_OPT_ILIM;
      end else begin
         opt_ilim <= I_OPT_INPUT_CURRENT;
      end
   end

   always_ff @(posedge I_REF_CLK) begin
      if (I_SYS_RST || I_REG_RESET) begin
         O_WATCHDOG_RESTART     <= 1'b0;
         O_SAFETY_TIMER_RESTART <= 1'b0;
      end else begin
         O_WATCHDOG_RESTART     <= period_change || (wr_ctl3 && I_WR_DATA[`C3_KICK]);
         O_SAFETY_TIMER_RESTART <= duration_change;
      end
   end

   always_ff @(posedge I_REF_CLK) begin
      if (I_SYS_RST) begin
         O_BUCK_ACTIVE       <= 1'b0;
         O_SAFETY_HALF_RATE  <= 1'b0;
         O_RUN_SOURCE_DETECT <= 1'b0;
      end else begin
         O_BUCK_ACTIVE       <= ctl2[`C2_OTG] && !ctl2[`C2_CHG];
         O_SAFETY_HALF_RATE  <= ctl1[`C1_HALF] && (I_INPUT_REG_ACTIVE || I_THERMAL_REG_ACTIVE);
         O_RUN_SOURCE_DETECT <= ctl2[`C2_AUTO] && I_SOURCE_PLUG_IN;
      end
   end

   always_ff @(posedge I_REF_CLK) begin
      if (I_SYS_RST) begin
         O_BUCK_VOLTAGE_SETTING <= nibble_t'(`RST_OTG);
      end else if (otg[`OTG_V_HI:`OTG_V_LO] > `OTG_V_MAX) begin
         O_BUCK_VOLTAGE_SETTING <= `OTG_V_MAX;
      end else begin
         O_BUCK_VOLTAGE_SETTING <= otg[`OTG_V_HI:`OTG_V_LO];
      end
   end

   // Read decode; unmapped offsets return zero
   always_comb begin
      next_rd_data = 8'h00;
      if (hit(I_ADDR, `OFS_PRE_TERM)) begin
         next_rd_data = pre_term;
      end else if (hit(I_ADDR, `OFS_CTL1)) begin
         next_rd_data = ctl1;
      end else if (hit(I_ADDR, `OFS_CTL2)) begin
         next_rd_data = ctl2;
      end else if (hit(I_ADDR, `OFS_CTL3)) begin
         next_rd_data = ctl3 | {1'b0, kick, 6'h00};
      end else if (hit(I_ADDR, `OFS_DERATE)) begin
         next_rd_data = derate;
      end else if (hit(I_ADDR, `OFS_OTG)) begin
         next_rd_data = otg;
      end else if (hit(I_ADDR, `OFS_OPT_ILIM)) begin
         next_rd_data = {3'h0, opt_ilim};
      end
   end

   always_ff @(posedge I_REF_CLK) begin
      if (I_SYS_RST) begin
         O_RD_DATA  <= 8'h00;
         O_RD_VALID <= 1'b0;
      end else begin
         O_RD_VALID <= I_RD_EN;
         if (I_RD_EN) begin
            O_RD_DATA <= next_rd_data;
         end
      end
   end

   assign O_PRECHARGE_CURRENT_CODE    = pre_term[`PRE_HI:`PRE_LO];
   assign O_END_CURRENT_CODE          = pre_term[`END_HI:`END_LO];
   assign O_TERMINATION_ENABLE        = ctl1[`C1_TERM];
   assign O_HOST_TIMEOUT_PERIOD       = ctl1[`C1_WD_HI:`C1_WD_LO];
   assign O_SAFETY_TIMER_ENABLE       = ctl1[`C1_TMR_EN];
   assign O_FAST_CHARGE_DURATION      = ctl1[`C1_DUR_HI:`C1_DUR_LO];
   assign O_HALF_SPEED_TIMER_ENABLE   = ctl1[`C1_HALF];
   assign O_BUCK_OUTPUT_ENABLE        = ctl2[`C2_OTG];
   assign O_AUTO_SOURCE_DETECT_ENABLE = ctl2[`C2_AUTO];
   assign O_DIE_TEMP_THRESHOLD        = ctl2[`C2_DIE_TEMP_THRESHOLD_HI:`C2_DIE_TEMP_THRESHOLD_LO];
   assign O_CHARGING_ENABLE           = ctl2[`C2_CHG];
   assign O_PRECHARGE_EXIT_THRESHOLD  = ctl2[`C2_LOWV];
   assign O_RECHARGE_OFFSET           = ctl2[`C2_RECH_HI:`C2_RECH_LO];
   assign O_LIGHT_LOAD_MODE_OFF       = ctl3[`C3_PFM_OFF];
   assign O_AFTER_CHARGE_DURATION     = ctl3[`C3_TOP_HI:`C3_TOP_LO];
   assign O_MIN_SYSTEM_VOLTAGE        = ctl3[`C3_SYS_HI:`C3_SYS_LO];
   assign O_BUCK_HOT_THRESHOLD        = derate[`D_HOT_HI:`D_HOT_LO];
   assign O_BUCK_COLD_THRESHOLD       = derate[`D_COLD];
   assign O_WARM_VOLTAGE_SETTING      = derate[`D_WV_HI:`D_WV_LO];
   assign O_WARM_CURRENT_SETTING      = derate[`D_WI];
   assign O_COOL_CURRENT_SETTING      = derate[`D_CI_HI:`D_CI_LO];
   assign O_BUCK_CURRENT_LIMIT        = otg[`OTG_I_HI:`OTG_I_LO];

   property p_period_restart;
      @(posedge I_REF_CLK) disable iff (I_SYS_RST || I_REG_RESET)
      (wr_ctl1 && !wr_ctl3) |=> (O_WATCHDOG_RESTART ==
         ($past(I_WR_DATA[`C1_WD_HI:`C1_WD_LO]) != $past(ctl1[`C1_WD_HI:`C1_WD_LO])));
   endproperty
   a_period_restart: assert property (p_period_restart) else $error("period restart wrong");

   property p_duration_restart;
      @(posedge I_REF_CLK) disable iff (I_SYS_RST || I_REG_RESET)
      wr_ctl1 |=> (O_SAFETY_TIMER_RESTART ==
         ($past(I_WR_DATA[`C1_DUR_HI:`C1_DUR_LO]) != $past(ctl1[`C1_DUR_HI:`C1_DUR_LO])));
   endproperty
   a_duration_restart: assert property (p_duration_restart) else $error("safety restart wrong");

   property p_kick;
      @(posedge I_REF_CLK) disable iff (I_SYS_RST || I_REG_RESET)
      (wr_ctl3 && I_WR_DATA[`C3_KICK]) |=> (kick && O_WATCHDOG_RESTART) ##1 (!kick || $past(wr_ctl3));
   endproperty
   a_kick: assert property (p_kick) else $error("kick not pulsed");

   property p_rsvd;
      @(posedge I_REF_CLK) disable iff (I_SYS_RST)
      wr_ctl1 |=> ((ctl1 & ~`CTL1_WMASK) == 8'h00);
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

   property p_wd_keep;
      @(posedge I_REF_CLK) disable iff (I_SYS_RST || I_REG_RESET)
      (I_WATCHDOG_EXPIRED && !I_WR_EN) |=> ((ctl2 & `CTL2_WD_KEEP) == $past(ctl2 & `CTL2_WD_KEEP))
         && ((ctl3 & `CTL3_WD_KEEP) == $past(ctl3 & `CTL3_WD_KEEP)) && ctl1 == `RST_CTL1 && otg == `RST_OTG;
   endproperty
   a_wd_keep: assert property (p_wd_keep) else $error("timeout clear wrong");

   property p_wd_clear;
      @(posedge I_REF_CLK) disable iff (I_SYS_RST || I_REG_RESET)
      (I_WATCHDOG_EXPIRED && !I_WR_EN) |=> pre_term == `RST_PRE_TERM && derate == `RST_DERATE && !kick
         && ((ctl2 & ~`CTL2_WD_KEEP) == (`RST_CTL2 & ~`CTL2_WD_KEEP))
         && ((ctl3 & ~`CTL3_WD_KEEP) == (`RST_CTL3 & ~`CTL3_WD_KEEP));
   endproperty
   a_wd_clear: assert property (p_wd_clear) else $error("timeout did not restore defaults");

   property p_reset_vals;
      @(posedge I_REF_CLK) I_REG_RESET |=> pre_term == `RST_PRE_TERM && ctl1 == `RST_CTL1 && ctl2 == `RST_CTL2
         && ctl3 == `RST_CTL3 && derate == `RST_DERATE && otg == `RST_OTG && !kick;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("defaults wrong");

   property p_charge_wins;
      @(posedge I_REF_CLK) disable iff (I_SYS_RST)
      ##1 (O_BUCK_ACTIVE == ($past(ctl2[`C2_OTG]) && !$past(ctl2[`C2_CHG])));
   endproperty
   a_charge_wins: assert property (p_charge_wins) else $error("charge priority lost");

   property p_half_rate;
      @(posedge I_REF_CLK) disable iff (I_SYS_RST)
      1'b1 |=> O_SAFETY_HALF_RATE == ($past(ctl1[`C1_HALF])
         && ($past(I_INPUT_REG_ACTIVE) || $past(I_THERMAL_REG_ACTIVE)));
   endproperty
   a_half_rate: assert property (p_half_rate) else $error("half rate wrong");

   property p_source_detect;
      @(posedge I_REF_CLK) disable iff (I_SYS_RST)
      1'b1 |=> O_RUN_SOURCE_DETECT == ($past(ctl2[`C2_AUTO]) && $past(I_SOURCE_PLUG_IN));
   endproperty
   a_source_detect: assert property (p_source_detect) else $error("source detect wrong");

   property p_clamp;
      @(posedge I_REF_CLK) disable iff (I_SYS_RST)
      O_BUCK_VOLTAGE_SETTING <= `OTG_V_MAX;
   endproperty
   a_clamp: assert property (p_clamp) else $error("buck voltage not clamped");

   property p_clamp_pass;
      @(posedge I_REF_CLK) disable iff (I_SYS_RST)
      1'b1 |=> O_BUCK_VOLTAGE_SETTING == (($past(otg[`OTG_V_HI:`OTG_V_LO]) > `OTG_V_MAX) ? `OTG_V_MAX
         : $past(otg[`OTG_V_HI:`OTG_V_LO]));
   endproperty
   a_clamp_pass: assert property (p_clamp_pass) else $error("buck voltage not passed through");

   property p_ro;
      @(posedge I_REF_CLK) disable iff (I_SYS_RST)
      (I_RD_EN && hit(I_ADDR, `OFS_OPT_ILIM)) |=> O_RD_VALID && O_RD_DATA[7:`OPT_ILIM_W] == '0
         && O_RD_DATA[`OPT_ILIM_W-1:0] == $past(opt_ilim);
   endproperty
   a_ro: assert property (p_ro) else $error("read-only readback wrong");

   property p_ro_write;
      @(posedge I_REF_CLK) disable iff (I_SYS_RST)
      (I_WR_EN && hit(I_ADDR, `OFS_OPT_ILIM) && !I_REG_RESET && !I_WATCHDOG_EXPIRED) |=> $stable(pre_term)
         && $stable(ctl1) && $stable(ctl2) && $stable(ctl3) && $stable(derate) && $stable(otg);
   endproperty
   a_ro_write: assert property (p_ro_write) else $error("read-only write changed state");

   property p_rd_valid;
      @(posedge I_REF_CLK) disable iff (I_SYS_RST)
      1'b1 |=> O_RD_VALID == $past(I_RD_EN);
   endproperty
   a_rd_valid: assert property (p_rd_valid) else $error("read valid pulse wrong");

endmodule // charger_control_registers

// ===== tb/host_model.sv
// Host side of the byte register bus: one-cycle write and read strobes.
// Assumes the bank answers a read with a one-cycle valid pulse the cycle after the strobe.
`timescale 1ns/1ns
module host_model (
   input  wire logic                        i_clk,
   input  wire logic                        i_rd_valid,
   input  wire charger_ctrl_pkg::reg_byte_t i_rd_data,
   output charger_ctrl_pkg::reg_byte_t      o_wr_data,
   output charger_ctrl_pkg::reg_addr_t      o_addr,
   output logic                             o_wr_en,
   output logic                             o_rd_en
);
   import charger_ctrl_pkg::*;
   initial begin
      o_wr_en = 1'b0;
      o_rd_en = 1'b0;
      o_addr = 8'h00;
      o_wr_data = 8'h00;
   end
   // kick is a plain write of one; released lines show the inverse
   task automatic wr(input reg_addr_t a, input reg_byte_t d);
      @(posedge i_clk);
      o_wr_en <= 1'b1;
      o_addr <= a;
      o_wr_data <= d;
      @(posedge i_clk);
      o_wr_en <= 1'b0;
      o_addr <= ~a;
      o_wr_data <= ~d;
   endtask
   task automatic rd(input reg_addr_t a, output reg_byte_t d, output bit ok);
      int n;
      @(posedge i_clk);
      o_rd_en <= 1'b1;
      o_addr <= a;
      @(posedge i_clk);
      o_rd_en <= 1'b0;
      o_addr <= ~a;
      ok = 1'b0;
      d = 8'h00;
      for (n = 0; n < 4 && !ok; n++) begin
         #1;
         if (i_rd_valid === 1'b1) begin
            ok = 1'b1;
            d = i_rd_data;
         end
         else @(posedge i_clk);
      end
   endtask
endmodule // host_model

// ===== tb/testbench.sv
// Self-checking bench for the charger configuration bank.
// Assumes the package, the bank and the host bus model are compiled before it.
`timescale 1ns/1ns
module testbench;
   import charger_ctrl_pkg::*;
   typedef struct {reg_addr_t a; reg_byte_t d; reg_byte_t r; reg_byte_t f;} row_t;
   logic            clk, rst, regrst, wdexp, inreg, threg, plug;
   logic [4:0]      opt;
   wire logic       wr_en, rd_en, rd_valid, buck_act, half_rate, run_det, host_timeout_kick, st_rst;
   wire reg_addr_t  addr;
   wire reg_byte_t  wdata, rdata;
   wire logic [7:0] f4, f5, f6, f7, f8, f9;
   int              n_fail = 0;
   int              cmp_count = 0;
   int              cyc = 0;
   reg_byte_t       v;
   bit              ok;
   // Address, write byte, read-back, field outputs at that offset (those of offset 0x09 for 0x0A and 0x1F)
   row_t rows [9] = '{'{8'h04, 8'hA5, 8'hA5, 8'hA5}, '{8'h05, 8'hFF, 8'hBF, 8'hBF},
      '{8'h06, 8'h5A, 8'h5A, 8'h5A}, '{8'h07, 8'hBF, 8'hBF, 8'hBF}, '{8'h08, 8'hF2, 8'hF2, 8'hF2},
      '{8'h09, 8'hFB, 8'hFB, 8'hFA}, '{8'h09, 8'h3A, 8'h3A, 8'h3A}, '{8'h0A, 8'hFF, 8'h13, 8'h3A},
      '{8'h1F, 8'h55, 8'h00, 8'h3A}};
   reg_byte_t dflt [4:9] = '{8'h22, 8'h9D, 8'h7D, 8'h0A, 8'h0D, 8'hF6};
   assign f5[6] = 1'b0;
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   host_model host_i (.i_clk(clk), .i_rd_valid(rd_valid), .i_rd_data(rdata), .o_wr_data(wdata),
      .o_addr(addr), .o_wr_en(wr_en), .o_rd_en(rd_en));
   charger_control_registers charger_control_registers_i (.I_REF_CLK(clk), .I_SYS_RST(rst),
      .I_WR_EN(wr_en), .I_RD_EN(rd_en), .I_ADDR(addr), .I_WR_DATA(wdata), .I_REG_RESET(regrst),
      .I_WATCHDOG_EXPIRED(wdexp), .I_INPUT_REG_ACTIVE(inreg), .I_THERMAL_REG_ACTIVE(threg),
      .I_SOURCE_PLUG_IN(plug), .I_OPT_INPUT_CURRENT(opt), .O_RD_DATA(rdata), .O_RD_VALID(rd_valid),
      .O_PRECHARGE_CURRENT_CODE(f4[7:4]), .O_END_CURRENT_CODE(f4[3:0]), .O_TERMINATION_ENABLE(f5[7]),
      .O_HOST_TIMEOUT_PERIOD(f5[5:4]), .O_SAFETY_TIMER_ENABLE(f5[3]), .O_FAST_CHARGE_DURATION(f5[2:1]),
      .O_HALF_SPEED_TIMER_ENABLE(f5[0]), .O_BUCK_OUTPUT_ENABLE(f6[7]), .O_AUTO_SOURCE_DETECT_ENABLE(f6[6]),
      .O_DIE_TEMP_THRESHOLD(f6[5:4]), .O_CHARGING_ENABLE(f6[3]), .O_PRECHARGE_EXIT_THRESHOLD(f6[2]),
      .O_RECHARGE_OFFSET(f6[1:0]), .O_LIGHT_LOAD_MODE_OFF(f7[7]), .O_AFTER_CHARGE_DURATION(f7[5:4]),
      .O_MIN_SYSTEM_VOLTAGE(f7[3:0]), .O_BUCK_HOT_THRESHOLD(f8[7:6]), .O_BUCK_COLD_THRESHOLD(f8[5]),
      .O_WARM_VOLTAGE_SETTING(f8[4:3]), .O_WARM_CURRENT_SETTING(f8[2]), .O_COOL_CURRENT_SETTING(f8[1:0]),
      .O_BUCK_CURRENT_LIMIT(f9[7:4]), .O_BUCK_VOLTAGE_SETTING(f9[3:0]), .O_BUCK_ACTIVE(buck_act),
      .O_SAFETY_HALF_RATE(half_rate), .O_RUN_SOURCE_DETECT(run_det), .O_WATCHDOG_RESTART(host_timeout_kick),
      .O_SAFETY_TIMER_RESTART(st_rst));
   // Bit 6 of f7 is the self-clearing kick, not a field output
   assign f7[6] = 1'b0;
   function automatic reg_byte_t fld(input reg_addr_t a);
      case (a)
         8'h04: return f4;
         8'h05: return f5;
         8'h06: return f6;
         8'h07: return f7;
         8'h08: return f8;
         default: return f9;
      endcase
   endfunction
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rdchk(input reg_addr_t a, input reg_byte_t e);
      host_i.rd(a, v, ok);
      chk("read valid", 8'h01, {7'h00, ok});
      chk($sformatf("read %h", a), e, v);
   endtask
   task automatic wrp(input reg_addr_t a, input reg_byte_t d, input logic ew, input logic es);
      host_i.wr(a, d);
      #1;
      chk("timeout restart", {7'h00, ew}, {7'h00, host_timeout_kick});
      chk("safety restart", {7'h00, es}, {7'h00, st_rst});
      @(posedge clk);
      #1;
      chk("restart pulse end", 8'h00, {6'h00, host_timeout_kick, st_rst});
   endtask
   task automatic lvl(input logic eh, input logic ed);
      repeat (2) @(posedge clk);
      #1;
      chk("half rate", {7'h00, eh}, {7'h00, half_rate});
      chk("source detect", {7'h00, ed}, {7'h00, run_det});
   endtask
   task automatic chk_dflt;
      for (int a = 4; a <= 9; a++) begin
         rdchk(a[7:0], dflt[a]);
         chk("field", dflt[a], fld(a[7:0]));
      end
   endtask
   task automatic end_of_test;
      $display("counts: %0d mismatches, %0d comparisons", n_fail, cmp_count);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end
      else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_fail++;
         end_of_test;
      end
   end
   initial begin
      rst = 1'b1;
      regrst = 1'b0;
      wdexp = 1'b0;
      inreg = 1'b0;
      threg = 1'b0;
      plug = 1'b0;
      opt = 5'h13;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      chk_dflt;
      $display("test reset values done");
      foreach (rows[i]) begin
         host_i.wr(rows[i].a, rows[i].d);
         rdchk(rows[i].a, rows[i].r);
         chk("field", rows[i].f, fld(rows[i].a));
      end
      $display("test register table done");
      @(posedge clk);
      regrst <= 1'b1;
      @(posedge clk);
      regrst <= 1'b0;
      chk_dflt;
      $display("test register reset done");
      wrp(8'h05, 8'h9D, 1'b0, 1'b0);
      wrp(8'h05, 8'h8D, 1'b1, 1'b0);
      wrp(8'h05, 8'h89, 1'b0, 1'b1);
      wrp(8'h07, 8'h4A, 1'b1, 1'b0);
      rdchk(8'h07, 8'h0A);
      $display("test restart pulses done");
      host_i.wr(8'h04, 8'h00);
      host_i.wr(8'h06, 8'hFE);
      host_i.wr(8'h07, 8'h8F);
      @(posedge clk);
      wdexp <= 1'b1;
      @(posedge clk);
      wdexp <= 1'b0;
      rdchk(8'h04, 8'h22);
      rdchk(8'h05, 8'h9D);
      rdchk(8'h06, 8'h7E);
      rdchk(8'h07, 8'h8F);
      $display("test timeout expiry done");
      host_i.wr(8'h06, 8'hF6);
      @(posedge clk);
      #1;
      chk("buck active", 8'h01, {7'h00, buck_act});
      host_i.wr(8'h06, 8'hFE);
      @(posedge clk);
      #1;
      chk("buck active", 8'h00, {7'h00, buck_act});
      @(posedge clk);
      inreg <= 1'b1;
      plug <= 1'b1;
      lvl(1'b1, 1'b1);
      @(posedge clk);
      inreg <= 1'b0;
      threg <= 1'b1;
      lvl(1'b1, 1'b1);
      host_i.wr(8'h05, 8'h9C);
      host_i.wr(8'h06, 8'hBE);
      lvl(1'b0, 1'b0);
      $display("test derived controls done");
      end_of_test;
   end
endmodule // testbench
